// file: tb/cpm_bus_model.sv
/*
 * cpm_bus_model: external bus side of the cache policy block; drives the
 * policy pin and answers each fill or write-through with one strobe.
 * Assumes req_ready low marks a bus cycle in flight.
 */
`timescale 1ns/100ps
module cpm_bus_model (
	input  wire logic       clk,                 // 100 MHz
	input  wire logic       reset_n,             // async, low
	input  wire logic       req_ready,           // low during bus cycle
	input  wire logic       policy,              // decoder result
	input  wire logic       use_na,              // answer with next address
	input  wire logic [3:0] dly,                 // wait before strobe, min 1
	output logic            line_policy_pin,     // high = write-back
	output logic            next_address_strobe, // bus strobe
	output logic            burst_ready_strobe   // bus strobe
);
	logic [3:0] cnt;
	logic       sent;
	logic       stb;

	assign line_policy_pin = policy;
	assign next_address_strobe = stb & use_na;
	assign burst_ready_strobe = stb & ~use_na;

	// counting from 0 up to a dly of at least 1 keeps the one-cycle invalidate stall unanswered
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt <= 4'h0;
			sent <= 1'b0;
			stb <= 1'b0;
		end
		else if (req_ready)
		begin
			cnt <= 4'h0;
			sent <= 1'b0;
			stb <= 1'b0;
		end
		else if (!sent && cnt == dly)
		begin
			sent <= 1'b1;
			stb <= 1'b1;
		end
		else
		begin
			cnt <= cnt + 4'h1;
			stb <= 1'b0;
		end
	end
endmodule

// file: tb/cpm_cache_policy_tb.sv
/*
 * cpm_cache_policy_tb: self-checking bench for the cache policy block.
 * Assumes the package, the design and the bus model are compiled first.
 */
`timescale 1ns/100ps
module cpm_cache_policy_tb;
	typedef struct {
		logic [1:0]  k;
		logic [15:0] vt;
		logic [15:0] pt;
		logic        pwt, ca, pin, na, hit, bw, al;
		logic [1:0]  way;
		logic [1:0]  st;
	} cpm_row_type;
	logic                  clk, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [3:0]            avs_address, dly;
	logic [31:0]           avs_writedata, avs_readdata, rd;
	logic                  req_valid, req_ready, inq_hit_modified;
	cpm_pkg::cpm_req_type  req;
	cpm_pkg::cpm_resp_type resp;
	cpm_pkg::cpm_inq_type  inq;
	logic                  line_policy_pin, policy, use_na;
	logic                  next_address_strobe, burst_ready_strobe;
	int                    num_errors = 0, total_checks = 0, cycles = 0;
	int                    wb_cnt = 0, hm_cnt = 0, base;
	// k vt pt pwt ca pin na | hit bw al way st
	cpm_row_type rows [13] = '{
		'{0, 16'h000a, 16'h000a, 0, 1, 1, 0, 0, 0, 1, 0, 2},
		'{0, 16'h000b, 16'h000b, 0, 1, 0, 0, 0, 0, 1, 1, 1},
		'{1, 16'h000a, 16'h000a, 0, 1, 1, 0, 1, 0, 0, 0, 3},
		'{1, 16'h000b, 16'h000b, 0, 1, 1, 0, 1, 1, 0, 1, 2},
		'{1, 16'h000b, 16'h000b, 1, 1, 0, 0, 1, 1, 0, 1, 2},
		'{1, 16'h000c, 16'h000c, 0, 1, 1, 0, 0, 1, 0, 0, 0},
		'{0, 16'h000c, 16'h000c, 0, 0, 1, 0, 0, 0, 0, 0, 0},
		'{0, 16'h000a, 16'h000a, 0, 1, 0, 0, 1, 0, 0, 0, 3},
		'{0, 16'h000c, 16'h000c, 0, 1, 0, 0, 0, 0, 1, 2, 1},
		'{0, 16'h000d, 16'h000d, 0, 1, 1, 1, 0, 0, 1, 3, 2},
		'{2, 16'h0010, 16'h0020, 0, 1, 1, 0, 0, 0, 1, 0, 1},
		'{2, 16'h0011, 16'h0020, 0, 1, 1, 0, 0, 0, 1, 0, 1},
		'{2, 16'h0011, 16'h0020, 0, 1, 1, 0, 1, 0, 0, 0, 1}};

	cpm_cache_policy DUT (.clk(clk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.resp(resp), .line_policy_pin(line_policy_pin),
		.next_address_strobe(next_address_strobe),
		.burst_ready_strobe(burst_ready_strobe), .inq(inq),
		.inq_hit_modified(inq_hit_modified));
	cpm_bus_model bus (.clk(clk), .reset_n(reset_n), .req_ready(req_ready),
		.policy(policy), .use_na(use_na), .dly(dly),
		.line_policy_pin(line_policy_pin),
		.next_address_strobe(next_address_strobe),
		.burst_ready_strobe(burst_ready_strobe));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// pulses are counted here so tests can look at them afterwards
	always @(posedge clk)
	begin
		cycles++;
		if (resp.writeback === 1'b1) wb_cnt++;
		if (inq_hit_modified === 1'b1) hm_cnt++;
		if (cycles == 5000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	task give_verdict();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input cpm_row_type r);
		logic [1:0] w;
		w = (r.hit | r.al) ? r.way : resp.way;
		total_checks++;
		if ({resp.hit, resp.bus_write, resp.allocate, resp.way, resp.state}
			!== {r.hit, r.bw, r.al, w, r.st})
		begin
			num_errors++;
			$display("BAD %0t resp %b for tag %h", $time, resp, r.vt);
		end
	endtask

	// request held until the edge that sees waitrequest low
	task automatic av(input logic wr, input logic [3:0] a,
		input logic [31:0] wd);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) @(posedge clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// one idle edge, so a following call never re-drives in this step
		@(posedge clk);
	endtask

	task automatic run_row(input cpm_row_type r);
		policy <= r.pin;
		use_na <= r.na;
		req <= cpm_pkg::cpm_req_type'{cpm_pkg::cpm_kind_type'(r.k), 8'h00,
			r.vt, r.pt, r.pwt, r.ca};
		req_valid <= 1'b1;
		@(posedge clk);
		while (req_ready !== 1'b1) @(posedge clk);
		req_valid <= 1'b0;
		@(posedge clk);
		while (resp.done !== 1'b1) @(posedge clk);
		chk_resp(r);
	endtask

	task automatic snoop(input logic [15:0] pt, input logic inv);
		inq <= cpm_pkg::cpm_inq_type'{1'b1, 8'h00, pt, inv};
		@(posedge clk);
		inq <= '0;
		repeat (2) @(posedge clk);
	endtask

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	initial
	begin
		reset_n = 1'b0;
		{avs_read, avs_write, req_valid, policy, use_na} = 5'h00;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		req = '0;
		inq = '0;
		dly = 4'h1;
		do_reset();
		av(1'b0, cpm_pkg::CTRL_OFFSET, 32'h0000_0000);
		chk_word(rd, cpm_pkg::CTRL_RESET);
		av(1'b0, 4'h8, 32'h0000_0000);
		chk_word(rd, 32'h0000_0000);
		foreach (rows[i])
			run_row(rows[i]);
		$display("table done");
		// replacement way forced by control field, then a dirty victim
		// byte order bit set as well: it must not change any outcome
		av(1'b1, cpm_pkg::CTRL_OFFSET, 32'h0000_0213);
		av(1'b0, cpm_pkg::CTRL_OFFSET, 32'h0000_0000);
		chk_word(rd, 32'h0000_0213);
		run_row('{0, 16'h000e, 16'h000e, 0, 1, 1, 0, 0, 0, 1, 2, 2});
		base = wb_cnt;
		av(1'b1, cpm_pkg::CTRL_OFFSET, 32'h0000_0011);
		run_row('{0, 16'h000f, 16'h000f, 0, 1, 1, 0, 0, 0, 1, 0, 2});
		chk_word(32'(wb_cnt - base), 32'h0000_0001);
		$display("flush way done");
		// inquiries from another master, slow bus
		av(1'b1, cpm_pkg::CTRL_OFFSET, 32'h0000_0001);
		dly <= 4'h3;
		snoop(16'h000d, 1'b0);
		run_row('{1, 16'h000d, 16'h000d, 0, 1, 0, 0, 1, 1, 0, 3, 1});
		run_row('{1, 16'h000e, 16'h000e, 0, 1, 1, 0, 1, 0, 0, 2, 3});
		base = hm_cnt;
		snoop(16'h000e, 1'b1);
		chk_word(32'(hm_cnt - base), 32'h0000_0001);
		run_row('{0, 16'h000e, 16'h000e, 0, 1, 0, 0, 0, 0, 1, 2, 1});
		$display("inquiry done");
		// invalidate-all empties every way without a chip reset
		av(1'b1, cpm_pkg::CTRL_OFFSET, 32'h0000_0005);
		// counter cleared by the pulse; last victim still way 2
		av(1'b0, cpm_pkg::STATUS_OFFSET, 32'h0000_0000);
		chk_word(rd, 32'h0000_0200);
		av(1'b0, cpm_pkg::CTRL_OFFSET, 32'h0000_0000);
		chk_word(rd, 32'h0000_0001);
		run_row('{0, 16'h000f, 16'h000f, 0, 1, 1, 0, 0, 0, 1, 0, 2});
		run_row('{0, 16'h000b, 16'h000b, 0, 1, 1, 0, 0, 0, 1, 1, 2});
		$display("invalidate done");
		av(1'b1, cpm_pkg::CTRL_OFFSET, 32'h0000_0000);
		run_row('{1, 16'h000f, 16'h000f, 1, 1, 1, 0, 1, 1, 0, 0, 2});
		$display("simple variant done");
		do_reset();
		// counter restarts at zero; one counting edge precedes the read
		av(1'b0, cpm_pkg::STATUS_OFFSET, 32'h0000_0000);
		chk_word(rd, 32'h0000_0001);
		av(1'b0, cpm_pkg::CTRL_OFFSET, 32'h0000_0000);
		chk_word(rd, cpm_pkg::CTRL_RESET);
		run_row('{0, 16'h000f, 16'h000f, 0, 1, 1, 0, 0, 0, 1, 0, 2});
		$display("second reset done");
		give_verdict();
	end
endmodule

// file: verilog/cpm_cache_policy.sv
/*
 * cpm_cache_policy: per-line update policy, way replacement and line
 * state keeping for a four-way data cache and instruction cache.
 * Assumes one 100 MHz clock, inputs synchronous to it, and an external
 * bus that returns fill strobes and inquiry cycles.
 */
// The Avalon-MM register port and the register addresses were chosen for this implementation.
// How it works
// - cached data keeps memory byte order; byte order bit has no effect here
// - write-back: write hits stay in cache until replaced or flushed
// - write-through: write hit updates the line and goes to the bus
// - simple variant: page write-through bit makes the page uncacheable
// - coherent variant: line policy pin picks write-back or write-through
// - page write-through bit forces write-through whatever the pin says
// - write-once: first write goes to bus, later writes are write-back
// - simple variant: one valid bit per virtual tag, duplicates allowed
// - coherent variant: shared valid bit, fetch on every virtual miss
// - coherent fetch with physical hit overwrites that same line
// - simple variant: victim way chosen pseudorandomly
// - coherent variant: lowest invalid way first, else pseudorandom
// - hardware reset clears the replacement counters
// - invalidate-all control clears lines and replacement counters
// - nonzero replacement control uses the replacement way field
// - data lines use four states, instruction lines only shared/invalid
// - M/E write stays off bus; S goes to bus too; I only to bus
// - M stale memory sole copy; E clean sole; S clean maybe shared
// - inquiry cycles update the matching data line state
// - only cacheable read misses and any instruction fetch miss allocate; store misses go to the bus
// - data fill ends shared if coherent and pin low at strobe, otherwise exclusive
// - write-through on shared line moves to exclusive when pin high
// - write hit on E gives M; replacement write-back of M gives I
`timescale 1ns/100ps
module cpm_cache_policy #(
	parameter int SET_W = 2,
	parameter int TAG_W = 16
) (
	input  wire logic                 clk,                 // 100 MHz
	input  wire logic                 reset_n,             // async, low
	input  wire logic [3:0]           avs_address,         // byte address
	input  wire logic                 avs_read,            // read request
	input  wire logic                 avs_write,           // write request
	input  wire logic [31:0]          avs_writedata,       // write data
	output logic [31:0]               avs_readdata,        // read data
	output logic                      avs_waitrequest,     // stall
	input  wire logic                 req_valid,           // core access
	input  wire cpm_pkg::cpm_req_type req,                 // access info
	output logic                      req_ready,           // take access
	output cpm_pkg::cpm_resp_type     resp,                // decision
	input  wire logic                 line_policy_pin,     // high = WB
	input  wire logic                 next_address_strobe, // bus strobe
	input  wire logic                 burst_ready_strobe,  // bus strobe
	input  wire cpm_pkg::cpm_inq_type inq,                 // inquiry
	output logic                      inq_hit_modified     // snoop hit M
);
	typedef enum {ST_IDLE, ST_FILL, ST_WT} cpm_fsm_type;

	logic [1:0]            rst_sync;
	logic                  rst_n;
	logic [31:0]           ctrl;
	logic                  inval_pulse;
	logic                  bus_ack;
	logic [7:0]            rnd_cnt;
	logic [1:0]            last_victim;
	cpm_fsm_type           fsm;
	cpm_pkg::cpm_mesi_type dstate [2**SET_W][cpm_pkg::WAYS];
	logic [TAG_W-1:0]      dvtag  [2**SET_W][cpm_pkg::WAYS];
	logic [TAG_W-1:0]      dptag  [2**SET_W][cpm_pkg::WAYS];
	logic                  ivalid [2**SET_W][cpm_pkg::WAYS];
	logic [TAG_W-1:0]      ivtag  [2**SET_W][cpm_pkg::WAYS];
	logic [TAG_W-1:0]      iptag  [2**SET_W][cpm_pkg::WAYS];
	logic [SET_W-1:0]      set;
	logic [SET_W-1:0]      fill_set;
	logic [1:0]            fill_way;
	logic                  fill_instr;
	logic [TAG_W-1:0]      fill_vtag;
	logic [TAG_W-1:0]      fill_ptag;
	logic [1:0]            wt_way;
	logic [3:0]            d_hit;
	logic [3:0]            d_valid;
	logic [3:0]            i_hit;
	logic [3:0]            i_phit;
	logic [3:0]            i_valid;
	logic                  coherent;
	logic [1:0]            rc;
	logic [1:0]            rb;
	logic                  take;
	logic                  strobe;

	// reset release
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// one-hot hit vector to way number
	function automatic logic [1:0] way_of(input logic [3:0] v);
		way_of = 2'h0;
		for (int w = cpm_pkg::WAYS - 1; w >= 0; w--)
			if (v[w])
				way_of = w[1:0];
	endfunction

	// victim choice shared by both caches
	function automatic logic [1:0] pick_way(
		input logic [3:0] valid,
		input logic       coh,
		input logic [1:0] rctl,
		input logic [1:0] rway,
		input logic [7:0] cnt
	);
		if (rctl != 2'h0)
			pick_way = rway;
		else if (coh && (valid != 4'hf))
			pick_way = way_of(~valid);
		else
			pick_way = cnt[1:0] ^ cnt[5:4];
	endfunction

	assign coherent = ctrl[cpm_pkg::CTRL_COHERENT_BIT];
	assign rc       = ctrl[cpm_pkg::CTRL_RC_LSB +: 2];
	assign rb       = ctrl[cpm_pkg::CTRL_RB_LSB +: 2];
	assign set      = req.set[SET_W-1:0];
	assign strobe   = next_address_strobe | burst_ready_strobe;
	assign req_ready = (fsm == ST_IDLE) && !inval_pulse;
	assign take     = req_valid && req_ready;

	always_comb
	begin
		for (int w = 0; w < cpm_pkg::WAYS; w++)
		begin
			d_valid[w] = dstate[set][w] != cpm_pkg::LINE_I;
			d_hit[w]   = d_valid[w] && dvtag[set][w] == req.vtag[TAG_W-1:0];
			i_valid[w] = ivalid[set][w];
			i_hit[w]   = i_valid[w] && ivtag[set][w] == req.vtag[TAG_W-1:0];
			i_phit[w]  = i_valid[w] && iptag[set][w] == req.ptag[TAG_W-1:0];
		end
	end

	// register slave, one wait state on every access
	assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bus_ack <= 1'b0;
		else
			bus_ack <= (avs_read || avs_write) && !bus_ack;
	end

	// byte order bit is stored for software only; cache data is never swapped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl <= cpm_pkg::CTRL_RESET;
		else if (avs_write && bus_ack && avs_address == cpm_pkg::CTRL_OFFSET)
		begin
			ctrl <= avs_writedata;
			ctrl[cpm_pkg::CTRL_INVALIDATE] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			inval_pulse <= 1'b0;
		else
			inval_pulse <= avs_write && bus_ack
				&& avs_address == cpm_pkg::CTRL_OFFSET
				&& avs_writedata[cpm_pkg::CTRL_INVALIDATE];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			avs_readdata <= 32'h0;
		else if (avs_read && !bus_ack)
			unique case (avs_address)
				cpm_pkg::CTRL_OFFSET:   avs_readdata <= ctrl;
				cpm_pkg::STATUS_OFFSET: avs_readdata <= {19'h0,
					fsm != ST_IDLE, 2'h0, last_victim, rnd_cnt};
				default:                avs_readdata <= 32'h0;
			endcase
	end

	// free-running replacement counter; zero gives a repeatable sequence
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rnd_cnt <= cpm_pkg::RAND_RESET;
		else if (inval_pulse)
			rnd_cnt <= cpm_pkg::RAND_RESET;
		else
			rnd_cnt <= rnd_cnt + 8'h01;
	end

	inval_cnt_a: assert property (@(posedge clk) disable iff (!rst_n)
		inval_pulse |=> rnd_cnt == 8'h00)
		else $error("replacement counter not cleared by invalidate");

	// access decisions and the small fill / write-through sequencer
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fsm         <= ST_IDLE;
			resp        <= '0;
			fill_set    <= '0;
			fill_way    <= 2'h0;
			fill_instr  <= 1'b0;
			fill_vtag   <= '0;
			fill_ptag   <= '0;
			wt_way      <= 2'h0;
			last_victim <= 2'h0;
		end
		else
		begin
			resp.done      <= 1'b0;
			resp.writeback <= 1'b0;
			unique case (fsm)
				ST_IDLE:
					if (take)
					begin
						resp.bus_write <= 1'b0;
						resp.allocate  <= 1'b0;
						fill_set  <= set;
						fill_vtag <= req.vtag[TAG_W-1:0];
						fill_ptag <= req.ptag[TAG_W-1:0];
						unique case (req.kind)
							cpm_pkg::ACC_IFETCH:
								if (|i_hit)
								begin
									resp.done  <= 1'b1;
									resp.hit   <= 1'b1;
									resp.way   <= way_of(i_hit);
									resp.state <= cpm_pkg::LINE_S;
								end
								else
								begin
									// coherent: physical hit is refilled in place
									fill_way <= (coherent && |i_phit) ? way_of(i_phit)
										: pick_way(i_valid, coherent, rc, rb, rnd_cnt);
									last_victim <= (coherent && |i_phit) ? way_of(i_phit)
										: pick_way(i_valid, coherent, rc, rb, rnd_cnt);
									fill_instr <= 1'b1;
									resp.hit   <= 1'b0;
									fsm        <= ST_FILL;
								end
							cpm_pkg::ACC_READ:
								if (|d_hit)
								begin
									resp.done  <= 1'b1;
									resp.hit   <= 1'b1;
									resp.way   <= way_of(d_hit);
									resp.state <= dstate[set][way_of(d_hit)];
								end
								else if (req.cacheable && (coherent
									|| !req.page_write_through_bit))
								begin
									fill_way <= pick_way(d_valid, coherent, rc, rb, rnd_cnt);
									last_victim <= pick_way(d_valid, coherent, rc, rb,
										rnd_cnt);
									resp.writeback <= dstate[set][pick_way(d_valid,
										coherent, rc, rb, rnd_cnt)] == cpm_pkg::LINE_M;
									fill_instr <= 1'b0;
									resp.hit   <= 1'b0;
									fsm        <= ST_FILL;
								end
								else
								begin
									resp.done  <= 1'b1;
									resp.hit   <= 1'b0;
									resp.state <= cpm_pkg::LINE_I;
								end
							default:
								if (!(|d_hit))
								begin
									// store miss: posted to the bus, no allocation
									resp.done      <= 1'b1;
									resp.hit       <= 1'b0;
									resp.bus_write <= 1'b1;
									resp.state     <= cpm_pkg::LINE_I;
								end
								else
								begin
									resp.hit <= 1'b1;
									resp.way <= way_of(d_hit);
									if (!coherent)
									begin
										resp.done      <= 1'b1;
										resp.bus_write <= req.page_write_through_bit;
										resp.state     <= req.page_write_through_bit
											? dstate[set][way_of(d_hit)] : cpm_pkg::LINE_M;
									end
									else if (dstate[set][way_of(d_hit)] == cpm_pkg::LINE_S)
									begin
										// write-once: first write reaches the bus
										resp.bus_write <= 1'b1;
										wt_way <= way_of(d_hit);
										fsm    <= ST_WT;
									end
									else
									begin
										resp.done      <= 1'b1;
										resp.bus_write <= req.page_write_through_bit;
										resp.state     <= req.page_write_through_bit
											? dstate[set][way_of(d_hit)] : cpm_pkg::LINE_M;
									end
								end
						endcase
					end
				ST_FILL:
					if (strobe)
					begin
						resp.done     <= 1'b1;
						resp.allocate <= 1'b1;
						resp.way      <= fill_way;
						resp.state    <= (fill_instr
							|| (coherent && !line_policy_pin))
							? cpm_pkg::LINE_S : cpm_pkg::LINE_E;
						fsm <= ST_IDLE;
					end
				ST_WT:
					if (burst_ready_strobe)
					begin
						resp.done  <= 1'b1;
						resp.way   <= wt_way;
						resp.state <= line_policy_pin ? cpm_pkg::LINE_E
							: cpm_pkg::LINE_S;
						fsm <= ST_IDLE;
					end
			endcase
		end
	end

	// line state array: reset, invalidate-all, inquiry, then core updates
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int s = 0; s < 2**SET_W; s++)
				for (int w = 0; w < cpm_pkg::WAYS; w++)
				begin
					dstate[s][w] <= cpm_pkg::LINE_I;
					ivalid[s][w] <= 1'b0;
				end
		end
		else if (inval_pulse)
		begin
			for (int s = 0; s < 2**SET_W; s++)
				for (int w = 0; w < cpm_pkg::WAYS; w++)
				begin
					dstate[s][w] <= cpm_pkg::LINE_I;
					ivalid[s][w] <= 1'b0;
				end
		end
		else
		begin
			if (inq.valid)
				for (int w = 0; w < cpm_pkg::WAYS; w++)
					if (dstate[inq.set[SET_W-1:0]][w] != cpm_pkg::LINE_I
						&& dptag[inq.set[SET_W-1:0]][w] == inq.ptag[TAG_W-1:0])
					begin
						// another holder may now exist: no sole copy left
						dstate[inq.set[SET_W-1:0]][w] <= inq.invalidate
							? cpm_pkg::LINE_I : cpm_pkg::LINE_S;
						if (inq.invalidate)
							ivalid[inq.set[SET_W-1:0]][w] <= 1'b0;
					end
			if (take && req.kind == cpm_pkg::ACC_WRITE && |d_hit && !coherent
				&& !req.page_write_through_bit)
				dstate[set][way_of(d_hit)] <= cpm_pkg::LINE_M;
			if (take && req.kind == cpm_pkg::ACC_WRITE && |d_hit && coherent
				&& !req.page_write_through_bit
				&& dstate[set][way_of(d_hit)] == cpm_pkg::LINE_E)
				dstate[set][way_of(d_hit)] <= cpm_pkg::LINE_M;
			if (take && req.kind == cpm_pkg::ACC_READ && !(|d_hit)
				&& req.cacheable && (coherent || !req.page_write_through_bit))
				dstate[set][pick_way(d_valid, coherent, rc, rb, rnd_cnt)]
					<= cpm_pkg::LINE_I;
			if (take && req.kind == cpm_pkg::ACC_IFETCH && !(|i_hit))
				ivalid[set][(coherent && |i_phit) ? way_of(i_phit)
					: pick_way(i_valid, coherent, rc, rb, rnd_cnt)] <= 1'b0;
			if (fsm == ST_FILL && strobe && fill_instr)
				ivalid[fill_set][fill_way] <= 1'b1;
			if (fsm == ST_FILL && strobe && !fill_instr)
				dstate[fill_set][fill_way] <= (coherent && !line_policy_pin)
					? cpm_pkg::LINE_S : cpm_pkg::LINE_E;
			if (fsm == ST_WT && burst_ready_strobe && line_policy_pin)
				dstate[fill_set][wt_way] <= cpm_pkg::LINE_E;
		end
	end

	// tags carry no reset: a line is only looked at while its state is valid
	always_ff @(posedge clk)
	begin
		if (fsm == ST_FILL && strobe && fill_instr)
		begin
			ivtag[fill_set][fill_way] <= fill_vtag;
			iptag[fill_set][fill_way] <= fill_ptag;
		end
		if (fsm == ST_FILL && strobe && !fill_instr)
		begin
			dvtag[fill_set][fill_way] <= fill_vtag;
			dptag[fill_set][fill_way] <= fill_ptag;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			inq_hit_modified <= 1'b0;
		else
		begin
			inq_hit_modified <= 1'b0;
			if (inq.valid)
				for (int w = 0; w < cpm_pkg::WAYS; w++)
					if (dstate[inq.set[SET_W-1:0]][w] == cpm_pkg::LINE_M
						&& dptag[inq.set[SET_W-1:0]][w] == inq.ptag[TAG_W-1:0])
						inq_hit_modified <= 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence fill_end_s;
		fsm == ST_FILL && strobe && !fill_instr && coherent;
	endsequence
	sequence wr_hit_s;
		take && req.kind == cpm_pkg::ACC_WRITE && |d_hit && coherent;
	endsequence

	fill_excl_a: assert property (fill_end_s and line_policy_pin
		|=> dstate[fill_set][fill_way] == cpm_pkg::LINE_E && resp.done)
		else $error("fill with pin high did not end exclusive");
	fill_shared_a: assert property (fill_end_s and !line_policy_pin
		|=> dstate[fill_set][fill_way] == cpm_pkg::LINE_S)
		else $error("fill with pin low did not end shared");
	excl_write_a: assert property (wr_hit_s
		and !req.page_write_through_bit
		and dstate[set][way_of(d_hit)] == cpm_pkg::LINE_E
		|=> resp.done && !resp.bus_write && resp.state == cpm_pkg::LINE_M)
		else $error("exclusive write hit not silent or not modified");
	shared_write_a: assert property (wr_hit_s
		and dstate[set][way_of(d_hit)] == cpm_pkg::LINE_S
		|=> resp.bus_write && fsm == ST_WT)
		else $error("shared write hit did not go to the bus");
	pwt_force_a: assert property (wr_hit_s and req.page_write_through_bit
		|=> resp.bus_write)
		else $error("page write-through bit did not force bus write");
	store_miss_a: assert property (take && req.kind == cpm_pkg::ACC_WRITE
		&& !(|d_hit) |=> resp.done && resp.bus_write && !resp.allocate
		&& fsm == ST_IDLE)
		else $error("store miss allocated or stayed off the bus");
	first_inv_a: assert property (take && req.kind == cpm_pkg::ACC_READ
		&& !(|d_hit) && req.cacheable && coherent && rc == 2'h0
		&& !d_valid[0] |=> fill_way == 2'h0 ##[1:1000] resp.allocate)
		else $error("lowest invalid way not chosen or fill never ended");
	rc_way_a: assert property (take && req.kind == cpm_pkg::ACC_READ
		&& !(|d_hit) && req.cacheable && rc != 2'h0
		&& (coherent || !req.page_write_through_bit)
		|=> fill_way == $past(rb))
		else $error("replacement way field ignored");
	wt_excl_a: assert property (fsm == ST_WT && burst_ready_strobe
		&& line_policy_pin |=> dstate[fill_set][wt_way] == cpm_pkg::LINE_E
		&& resp.done && fsm == ST_IDLE)
		else $error("shared line not moved to exclusive");

endmodule

// file: verilog/cpm_pkg.sv
/*
 * cpm_pkg: constants and carrier types for the cache policy and line
 * state controller (register map, field layout, line states, requests).
 * Assumes a 32-bit Avalon-MM slave port and a four-way set layout.
 */
package cpm_pkg;

	localparam int WAYS = 4;
	localparam int ADDR_W = 4;

	// register byte offsets
	localparam logic [3:0] CTRL_OFFSET   = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;

	// control register fields
	localparam int CTRL_COHERENT_BIT  = 0;
	localparam int CTRL_BYTE_ORDER    = 1;
	localparam int CTRL_INVALIDATE    = 2;
	localparam int CTRL_RC_LSB        = 4;
	localparam int CTRL_RB_LSB        = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

	// status register fields
	localparam int STAT_RAND_LSB   = 0;
	localparam int STAT_VICTIM_LSB = 8;
	localparam int STAT_BUSY_BIT   = 12;

	localparam logic [7:0] RAND_RESET = 8'h00;

	typedef enum logic [1:0] {LINE_I, LINE_S, LINE_E, LINE_M} cpm_mesi_type;
	typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_IFETCH} cpm_kind_type;

	typedef struct packed {
		cpm_kind_type kind;
		logic [7:0]   set;
		logic [15:0]  vtag;
		logic [15:0]  ptag;
		logic         page_write_through_bit;
		logic         cacheable;
	} cpm_req_type;

	typedef struct packed {
		logic         done;
		logic         hit;
		logic         bus_write;
		logic         allocate;
		logic         writeback;
		logic [1:0]   way;
		cpm_mesi_type state;
	} cpm_resp_type;

	typedef struct packed {
		logic        valid;
		logic [7:0]  set;
		logic [15:0] ptag;
		logic        invalidate;
	} cpm_inq_type;

endpackage
